// >>> design/irq_ctrl_pkg.sv
// Purpose: Shared constants and types for the host CPU interrupt control block.
// Assumes: APB with 32-bit data; each register takes one aligned word at four times its index.
// Notes: The register indices are kept as printed; byte addresses derive from them.
package irq_ctrl_pkg;

  // Source count and bit positions, shared by enables, pending flags and clears.
  localparam int NUM_SRC = 5;
  localparam int SRC_VIDEO = 0;
  localparam int SRC_GFX = 1;
  localparam int SRC_OBJ = 2;
  localparam int SRC_TIMER = 3;
  localparam int SRC_COMP = 4;
  localparam int CLR_LSB = 8;

  // Field widths.
  localparam int VI_W = 11;
  localparam int PIT_W = 16;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 32;

  // Status bits that show the bus priority state.
  localparam int STAT_PRIO_BIT = 8;
  localparam int STAT_HOLD_BIT = 9;

  // Register indices; the byte address is four times the index.
  localparam logic [23:0] IDX_VI_LINE = 24'hF0004E;
  localparam logic [23:0] IDX_PIT_PRE = 24'hF00050;
  localparam logic [23:0] IDX_PIT_DIV = 24'hF00052;
  localparam logic [23:0] IDX_CONTROL = 24'hF000E0;
  localparam logic [23:0] IDX_RESUME = 24'hF000E2;
  localparam logic [23:0] IDX_STATUS = 24'hF000E4;

  // Byte addresses on the APB.
  localparam logic [ADDR_W-1:0] ADDR_VI_LINE = {6'h00, IDX_VI_LINE, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_PIT_PRE = {6'h00, IDX_PIT_PRE, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_PIT_DIV = {6'h00, IDX_PIT_DIV, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = {6'h00, IDX_CONTROL, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_RESUME = {6'h00, IDX_RESUME, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_STATUS = {6'h00, IDX_STATUS, 2'h0};

  // Reset values.
  localparam logic [NUM_SRC-1:0] RST_ENABLE = 5'h00;
  localparam logic [VI_W-1:0] RST_VI_LINE = 11'h000;
  localparam logic [PIT_W-1:0] RST_PIT = 16'h0000;

  // One bit per source.
  typedef logic [NUM_SRC-1:0] src_vec_t;

  // Event inputs from the rest of the chip.
  typedef struct packed {
    logic [VI_W-1:0] video_half_line;
    logic gfxproc_irq_write;
    logic objproc_stop;
    logic companion_irq;
  } src_in_t;

  // Bus priority requests towards the memory arbiter.
  typedef struct packed {
    logic gfxproc_prio_low;
    logic blitter_prio_low;
  } bus_prio_t;

  // Bus priority sequence.
  typedef enum logic [1:0] {
    PRIO_NORMAL,
    PRIO_REDUCED,
    PRIO_RESUME_HOLD
  } prio_state_t;

endpackage

// >>> design/irq_pending_bank.sv
// Purpose: Sticky pending flags, one per interrupt source.
// Assumes: Set and clear are one-cycle requests in the pclk domain.
// Notes: A set in the same cycle as a clear wins, so no event is lost.
`timescale 1ns/1ns
module irq_pending_bank (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Requests.
  input wire irq_ctrl_pkg::src_vec_t set_evt,
  input wire irq_ctrl_pkg::src_vec_t clr_req,
  // Flags.
  output irq_ctrl_pkg::src_vec_t pending
);
  import irq_ctrl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // All state of this module.
  typedef struct packed {
    src_vec_t pend;
  } bank_state_t;

  bank_state_t st_q; // Registered flags.
  bank_state_t st_d; // Next flags.
  src_vec_t pend_next; // Per-bit next value.

  // Each flag sets on its event and clears on request; the set has priority.
  for (genvar i = 0; i < NUM_SRC; i++) begin : g_flag
    assign pend_next[i] = set_evt[i] | (st_q.pend[i] & ~clr_req[i]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state.
  always_comb begin
    st_d = st_q;
    st_d.pend = pend_next;
  end

  // Flags clear on reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pending = st_q.pend;

endmodule

// >>> design/interval_timer.sv
// Purpose: Two-stage programmable interval timer producing one-cycle ticks.
// Assumes: Prescale and divide values come from software registers.
// Notes: A prescale of zero stops the timer; a reload restarts both stages.
`timescale 1ns/1ns
module interval_timer #(
  parameter int W = irq_ctrl_pkg::PIT_W
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Settings.
  input wire logic [W-1:0] prescale,
  input wire logic [W-1:0] divide,
  input wire logic reload,
  // Output event.
  output logic tick
);
  import irq_ctrl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // All state of this module.
  typedef struct packed {
    logic [W-1:0] cnt_pre;
    logic [W-1:0] cnt_div;
    logic tick;
  } tmr_state_t;

  tmr_state_t st_q; // Registered state.
  tmr_state_t st_d; // Next state.

  // The clock is divided by prescale plus one, then by divide plus one.
  always_comb begin
    st_d = st_q;
    st_d.tick = 1'b0;
    if (reload || prescale == '0) begin
      // Restart, or hold still while disabled.
      st_d.cnt_pre = prescale;
      st_d.cnt_div = divide;
    end else if (st_q.cnt_pre != '0) begin
      st_d.cnt_pre = st_q.cnt_pre - 1'b1;
    end else begin
      st_d.cnt_pre = prescale;
      if (st_q.cnt_div != '0) begin
        st_d.cnt_div = st_q.cnt_div - 1'b1;
      end else begin
        st_d.cnt_div = divide;
        st_d.tick = 1'b1;
      end
    end
  end

  // Registered so the tick is a clean one-cycle pulse.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tick = st_q.tick;

endmodule

// >>> design/host_cpu_irq_ctrl.sv
// Purpose: Host CPU interrupt control with bus priority handling, reached over APB.
// Assumes: All inputs are synchronous to pclk; APB slave answers with no wait states.
// Notes: Pending flags double as the sticky status; enables act as the mask.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ns
module host_cpu_irq_ctrl (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [irq_ctrl_pkg::ADDR_W-1:0] paddr,
  input wire logic [irq_ctrl_pkg::DATA_W-1:0] pwdata,
  output logic pready,
  output logic [irq_ctrl_pkg::DATA_W-1:0] prdata,
  output logic pslverr,
  // Interrupt sources and bus master activity.
  input wire irq_ctrl_pkg::src_in_t src_in,
  input wire logic gfxproc_busy,
  input wire logic blitter_busy,
  // CPU and arbiter side.
  output logic cpu_irq,
  output logic cpu_hold,
  output irq_ctrl_pkg::bus_prio_t bus_prio
);
  import irq_ctrl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // All state of this module.
  typedef struct packed {
    src_vec_t enable; // Per-source enables, also the interrupt mask.
    logic [VI_W-1:0] vi_line; // Half line for the video source.
    logic [PIT_W-1:0] pit_pre; // Timer prescale.
    logic [PIT_W-1:0] pit_div; // Timer divide.
    logic [DATA_W-1:0] rdata; // Read data captured in the setup phase.
    logic slverr; // Error answer captured in the setup phase.
    logic vid_match; // Video compare result of the last cycle.
    logic comp_level; // Companion input level of the last cycle.
    logic irq_seen; // Request output level of the last cycle.
    prio_state_t prio; // Bus priority sequence.
  } ctrl_state_t;

  ctrl_state_t st_q; // Registered state.
  ctrl_state_t st_d; // Next state.

  src_vec_t pending; // Sticky flags from the bank.
  src_vec_t set_evt; // One-cycle source events.
  src_vec_t clr_req; // One-cycle clear requests.
  logic timer_tick; // Timer output event.
  logic pit_reload; // Timer settings were written.
  logic vid_match_now; // Time-base sits on the selected half line.
  logic irq_now; // Any enabled flag pending.
  logic irq_rise; // A new interrupt is delivered to the CPU.
  logic xfer_busy; // Graphics processor or blitter still working.
  logic setup_ph; // APB setup phase.
  logic wr_acc; // APB write access completes.
  logic wr_ctrl; // Write to the control register.
  logic wr_resume; // Write to the resume register.
  logic wr_status; // Write to the status register.

  ////////////////////////////////////////////////////////////////////////////
  // APB decode. The slave never inserts wait states, so an access phase
  // always completes at its first edge.
  assign pready = 1'b1;
  assign setup_ph = psel & ~penable;
  assign wr_acc = psel & penable & pwrite & pready;
  assign wr_ctrl = wr_acc && (paddr == ADDR_CONTROL);
  assign wr_resume = wr_acc && (paddr == ADDR_RESUME);
  assign wr_status = wr_acc && (paddr == ADDR_STATUS);
  assign pit_reload = wr_acc && (paddr == ADDR_PIT_PRE || paddr == ADDR_PIT_DIV);

  // Read data and error come from flip-flops filled during the setup phase.
  assign prdata = st_q.rdata;
  assign pslverr = st_q.slverr & psel & penable;

  ////////////////////////////////////////////////////////////////////////////
  // Source events. The video source fires once on entering the half line,
  // not on every cycle spent there.
  assign vid_match_now = (src_in.video_half_line == st_q.vi_line);

  always_comb begin
    set_evt = '0;
    set_evt[SRC_VIDEO] = vid_match_now & ~st_q.vid_match;
    set_evt[SRC_GFX] = src_in.gfxproc_irq_write;
    set_evt[SRC_OBJ] = src_in.objproc_stop;
    set_evt[SRC_TIMER] = timer_tick;
    // The edge is only taken while enabled, so a level already high when
    // software enables the source does not count until it rises again.
    set_evt[SRC_COMP] = src_in.companion_irq & ~st_q.comp_level & st_q.enable[SRC_COMP];
  end

  // Clears come from the control register or from the status alias.
  always_comb begin
    clr_req = '0;
    if (wr_ctrl) begin
      clr_req = pwdata[CLR_LSB +: NUM_SRC];
    end
    if (wr_status) begin
      clr_req = clr_req | pwdata[NUM_SRC-1:0];
    end
  end

  // The request follows the masked flags as a level.
  assign irq_now = |(pending & st_q.enable);
  assign irq_rise = irq_now & ~st_q.irq_seen;
  assign xfer_busy = gfxproc_busy | blitter_busy;

  ////////////////////////////////////////////////////////////////////////////
  // Next state: registers, read capture and the priority sequence.
  always_comb begin
    st_d = st_q;
    st_d.vid_match = vid_match_now;
    st_d.comp_level = src_in.companion_irq;
    st_d.irq_seen = irq_now;
    // Register writes take effect at the completing access edge.
    if (wr_ctrl) begin
      st_d.enable = pwdata[NUM_SRC-1:0];
    end
    if (wr_acc && paddr == ADDR_VI_LINE) begin
      st_d.vi_line = pwdata[VI_W-1:0];
    end
    if (wr_acc && paddr == ADDR_PIT_PRE) begin
      st_d.pit_pre = pwdata[PIT_W-1:0];
    end
    if (wr_acc && paddr == ADDR_PIT_DIV) begin
      st_d.pit_div = pwdata[PIT_W-1:0];
    end
    // Read data is chosen in the setup phase so it comes from a flop.
    if (setup_ph) begin
      st_d.rdata = '0;
      st_d.slverr = 1'b0;
      case (paddr)
        ADDR_CONTROL: begin
          // Only the flags are visible; the upper bits read as zero.
          if (!pwrite) begin
            st_d.rdata[NUM_SRC-1:0] = pending;
          end
        end
        ADDR_STATUS: begin
          if (!pwrite) begin
            st_d.rdata[NUM_SRC-1:0] = pending;
            st_d.rdata[STAT_PRIO_BIT] = (st_q.prio == PRIO_REDUCED);
            st_d.rdata[STAT_HOLD_BIT] = (st_q.prio == PRIO_RESUME_HOLD);
          end
        end
        // Write-only registers read as zero.
        ADDR_RESUME, ADDR_VI_LINE, ADDR_PIT_PRE, ADDR_PIT_DIV: begin
          st_d.rdata = '0;
        end
        // Unmapped addresses answer with an error.
        default: begin
          st_d.slverr = 1'b1;
        end
      endcase
    end
    // Priority sequence. A resume that lands while a request is still
    // asserted leaves priority normal until the next delivery.
    case (st_q.prio)
      PRIO_NORMAL: begin
        if (irq_rise) begin
          st_d.prio = PRIO_REDUCED;
        end
      end
      PRIO_REDUCED: begin
        if (wr_resume) begin
          // Any data value restores the priorities.
          st_d.prio = xfer_busy ? PRIO_RESUME_HOLD : PRIO_NORMAL;
        end
      end
      PRIO_RESUME_HOLD: begin
        // The CPU waits until a new interrupt or the pending operation ends.
        if (irq_rise) begin
          st_d.prio = PRIO_REDUCED;
        end else if (!xfer_busy) begin
          st_d.prio = PRIO_NORMAL;
        end
      end
      default: begin
        st_d.prio = PRIO_NORMAL;
      end
    endcase
  end

  // State register; reset gives cleared enables and normal priority.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.
  assign cpu_irq = irq_now;
  assign cpu_hold = (st_q.prio == PRIO_RESUME_HOLD);
  assign bus_prio.gfxproc_prio_low = (st_q.prio == PRIO_REDUCED);
  assign bus_prio.blitter_prio_low = (st_q.prio == PRIO_REDUCED);

  ////////////////////////////////////////////////////////////////////////////
  // Sub-blocks.
  irq_pending_bank irq_pending_bank_inst (
    .pclk(pclk),
    .presetn(presetn),
    .set_evt(set_evt),
    .clr_req(clr_req),
    .pending(pending)
  );

  interval_timer #(
    .W(PIT_W)
  ) interval_timer_inst (
    .pclk(pclk),
    .presetn(presetn),
    .prescale(st_q.pit_pre),
    .divide(st_q.pit_div),
    .reload(pit_reload),
    .tick(timer_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the block's own behaviour.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // A resume write while an operation is still running.
  sequence resume_busy_s;
    wr_resume && st_q.prio == PRIO_REDUCED && xfer_busy;
  endsequence

  // The operation ends with no new interrupt.
  sequence xfer_done_s;
    !xfer_busy && !irq_rise;
  endsequence

  enable_load_a: assert property (wr_ctrl |=> st_q.enable == $past(pwdata[NUM_SRC-1:0]))
    else $error("Enables did not load from control write.");

  video_pend_a: assert property (set_evt[SRC_VIDEO] |=> pending[SRC_VIDEO] && !set_evt[SRC_VIDEO])
    else $error("Video half line match did not set one pending event.");

  gfx_pend_a: assert property (src_in.gfxproc_irq_write |=> pending[SRC_GFX])
    else $error("Graphics processor event lost.");

  obj_pend_a: assert property (src_in.objproc_stop |=> pending[SRC_OBJ])
    else $error("Stop object event lost.");

  timer_pend_a: assert property (timer_tick |=> pending[SRC_TIMER])
    else $error("Timer tick did not set pending.");

  comp_edge_a: assert property ($rose(src_in.companion_irq) && $past(st_q.enable[SRC_COMP])
    && st_q.enable[SRC_COMP] |=> pending[SRC_COMP])
    else $error("Companion rising edge did not set pending.");

  comp_level_a: assert property (!st_q.enable[SRC_COMP] && !pending[SRC_COMP]
    && !clr_req[SRC_COMP] |=> !pending[SRC_COMP])
    else $error("Companion pending set while disabled.");

  // Each clear bit empties its own flag, unless a new event lands at once.
  video_clear_a: assert property (wr_ctrl && pwdata[CLR_LSB + SRC_VIDEO] && !set_evt[SRC_VIDEO]
    |=> !pending[SRC_VIDEO])
    else $error("Video clear bit did not clear pending.");

  gfx_clear_a: assert property (wr_ctrl && pwdata[CLR_LSB + SRC_GFX] && !set_evt[SRC_GFX]
    |=> !pending[SRC_GFX])
    else $error("Graphics clear bit did not clear pending.");

  obj_clear_a: assert property (wr_ctrl && pwdata[CLR_LSB + SRC_OBJ] && !set_evt[SRC_OBJ]
    |=> !pending[SRC_OBJ])
    else $error("Object clear bit did not clear pending.");

  timer_clear_a: assert property (wr_ctrl && pwdata[CLR_LSB + SRC_TIMER] && !set_evt[SRC_TIMER]
    |=> !pending[SRC_TIMER])
    else $error("Timer clear bit did not clear pending.");

  comp_clear_a: assert property (wr_ctrl && pwdata[CLR_LSB + SRC_COMP] && !set_evt[SRC_COMP]
    |=> !pending[SRC_COMP])
    else $error("Companion clear bit did not clear pending.");

  ctrl_read_a: assert property (setup_ph && !pwrite && paddr == ADDR_CONTROL
    ##1 psel && penable |-> prdata == {{(DATA_W-NUM_SRC){1'b0}}, $past(pending)} && !pslverr)
    else $error("Control read data wrong.");

  prio_drop_a: assert property (st_q.prio == PRIO_NORMAL && irq_rise
    |=> bus_prio.gfxproc_prio_low && bus_prio.blitter_prio_low)
    else $error("Priority not lowered on delivered interrupt.");

  // A new interrupt lowers priority from the normal state and from the hold state alike.
  prio_any_a: assert property (irq_rise && st_q.prio != PRIO_REDUCED
    |=> bus_prio.gfxproc_prio_low && bus_prio.blitter_prio_low)
    else $error("Priority not lowered on a new interrupt.");

  resume_restore_a: assert property (wr_resume && st_q.prio == PRIO_REDUCED
    |=> !bus_prio.gfxproc_prio_low && !bus_prio.blitter_prio_low)
    else $error("Resume write did not restore priority.");

  resume_hold_a: assert property (resume_busy_s ##1 xfer_done_s |=> !cpu_hold)
    else $error("CPU hold not released when the operation ended.");

  hold_set_a: assert property (resume_busy_s |=> cpu_hold)
    else $error("CPU hold missing after resume with busy operation.");

  irq_follow_a: assert property (src_in.gfxproc_irq_write && st_q.enable[SRC_GFX] && !wr_ctrl
    |=> cpu_irq)
    else $error("Enabled pending source did not raise request.");

  // The request must follow the flags down, not only up.
  all_clear_a: assert property (wr_ctrl && (pending & ~pwdata[CLR_LSB +: NUM_SRC]) == '0
    && set_evt == '0 |=> !cpu_irq)
    else $error("Request stayed high after every flag cleared.");

  // A masked source must stay invisible to the CPU.
  mask_hold_a: assert property (src_in.objproc_stop && !st_q.enable[SRC_OBJ] && !wr_ctrl
    && (set_evt & st_q.enable) == '0 && (pending & st_q.enable) == '0 |=> !cpu_irq)
    else $error("Masked stop object raised the request.");

  // Enables only move on a control write.
  enable_keep_a: assert property (!wr_ctrl |=> $stable(st_q.enable))
    else $error("Enables changed without a control write.");

  // Reset is checked while it is held, so the usual disable is turned off.
  reset_clear_a: assert property (disable iff (1'b0) !presetn |-> st_q.enable == RST_ENABLE
    && pending == '0 && !bus_prio.gfxproc_prio_low && !cpu_hold)
    else $error("Reset state wrong.");

endmodule

// >>> testbench/busy_source_model.sv
// Purpose: Graphics processor and blitter activity as seen by the interrupt block.
// Assumes: A one-cycle start begins an operation that lasts run_len cycles.
// Notes: The blitter ends one cycle early, so the two busy lines differ.
`timescale 1ns/1ns
module busy_source_model (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Command from the bench.
  input wire logic start,
  input wire logic [3:0] run_len,
  // Activity towards the interrupt block.
  output logic gfxproc_busy,
  output logic blitter_busy
);
  // Cycles left in the running operation.
  logic [3:0] left_q;
  ////////////////////////////////////////////////////////////
  // Count the operation down; a fresh start reloads it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_q <= 4'h0;
    end else if (start) begin
      left_q <= run_len;
    end else if (left_q != 4'h0) begin
      left_q <= left_q - 4'h1;
    end
  end
  // The graphics line drops as the operation completes; the blitter line drops one cycle before.
  assign gfxproc_busy = (left_q != 4'h0);
  assign blitter_busy = (left_q > 4'h1);
endmodule

// >>> testbench/host_cpu_interrupt_control_test.sv
// Purpose: Self-checking bench for the host CPU interrupt control block.
// Assumes: APB slave answers in the access phase; sources sampled on pclk.
// Notes: Every service sequence ends with a resume write, as software must.
`timescale 1ns/1ns
module host_cpu_interrupt_control_test;
  import irq_ctrl_pkg::*;
  // Clock, reset and APB master signals.
  logic pclk = 1'b0;
  logic presetn = 1'b1; // Starts high so the drop at time zero is a real edge.
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  // Sources; the half line parks away from the compare value.
  src_in_t src = {11'h7FF, 3'h0};
  logic gfxproc_busy;
  logic blitter_busy;
  logic cpu_irq;
  logic cpu_hold;
  bus_prio_t bus_prio;
  // Partner command and bench bookkeeping.
  logic start = 1'b0;
  logic [31:0] rd;
  logic er;
  int failures = 0;
  int check_count = 0;
  ////////////////////////////////////////////////////////////
  // Clock of 100 MHz.
  always #5 pclk = ~pclk;
  host_cpu_irq_ctrl host_cpu_irq_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .src_in(src), .gfxproc_busy(gfxproc_busy), .blitter_busy(blitter_busy), .cpu_irq(cpu_irq),
    .cpu_hold(cpu_hold), .bus_prio(bus_prio));
  busy_source_model busy_source_model_inst (.pclk(pclk), .presetn(presetn), .start(start),
    .run_len(4'hF), .gfxproc_busy(gfxproc_busy), .blitter_busy(blitter_busy));
  ////////////////////////////////////////////////////////////
  // Compare and count; unknowns never match.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %0t %s: %h not %h", $time, what, seen, exp);
    end
  endtask
  // Print counts and verdict, then stop.
  task automatic report_and_stop;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // One APB transfer; the request holds until pready is seen high.
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      failures++;
      $display("unexpected %0t bus answer missing", $time);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr32(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd32(input logic [31:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  // Bounded wait for the request line.
  task automatic wait_irq;
    int n = 0;
    while (cpu_irq !== 1'b1 && n < 40) begin
      @(negedge pclk);
      n++;
    end
  endtask
  // One-cycle event pulses from the graphics and object processors.
  task automatic pulse(input logic g, input logic o);
    @(posedge pclk);
    src.gfxproc_irq_write <= g;
    src.objproc_stop <= o;
    @(posedge pclk);
    src.gfxproc_irq_write <= 1'b0;
    src.objproc_stop <= 1'b0;
  endtask
  // End of a service routine with the bus masters idle.
  task automatic finish_isr;
    wr32(ADDR_RESUME, 32'h0);
    @(negedge pclk);
    check({cpu_hold, bus_prio}, 3'h0, "resume idle");
  endtask
  ////////////////////////////////////////////////////////////
  // Full service with a busy master: priority drop, clear, resume, hold.
  task automatic t_gfx;
    int n = 0;
    wr32(ADDR_CONTROL, 32'h2);
    pulse(1'b1, 1'b0);
    @(negedge pclk);
    check(cpu_irq, 1'b1, "gfx irq");
    check(bus_prio, 2'h0, "prio early");
    @(negedge pclk);
    check(bus_prio, 2'h3, "prio low");
    rd32(ADDR_STATUS);
    check(rd, 32'h102, "status");
    @(posedge pclk);
    start <= 1'b1;
    @(posedge pclk);
    start <= 1'b0;
    wr32(ADDR_CONTROL, 32'h202);
    @(negedge pclk);
    check(cpu_irq, 1'b0, "gfx clear");
    wr32(ADDR_RESUME, 32'hFFFFFFFF);
    @(negedge pclk);
    check({cpu_hold, bus_prio}, 3'h4, "resume busy");
    while (cpu_hold === 1'b1 && n < 40) begin
      @(negedge pclk);
      n++;
    end
    check({gfxproc_busy, blitter_busy, cpu_hold, bus_prio}, 5'h0, "hold end");
  endtask
  // A disabled source still pends but is not forwarded until enabled.
  task automatic t_obj;
    wr32(ADDR_CONTROL, 32'h0);
    pulse(1'b0, 1'b1);
    repeat (2) @(negedge pclk);
    check(cpu_irq, 1'b0, "masked");
    rd32(ADDR_CONTROL);
    check(rd, 32'h4, "obj pending");
    wr32(ADDR_CONTROL, 32'h4);
    @(negedge pclk);
    check(cpu_irq, 1'b1, "unmasked");
    wr32(ADDR_CONTROL, 32'h404);
    @(negedge pclk);
    check(cpu_irq, 1'b0, "obj clear");
    finish_isr;
  endtask
  // Video event fires on entry to the chosen half line only.
  task automatic t_video;
    wr32(ADDR_VI_LINE, 32'h5);
    wr32(ADDR_CONTROL, 32'h1);
    src.video_half_line <= 11'h004;
    repeat (3) @(negedge pclk);
    check(cpu_irq, 1'b0, "other line");
    @(posedge pclk);
    src.video_half_line <= 11'h005;
    wait_irq;
    check(cpu_irq, 1'b1, "line hit");
    wr32(ADDR_CONTROL, 32'h101);
    repeat (3) @(negedge pclk);
    check(cpu_irq, 1'b0, "once per entry");
    @(posedge pclk);
    src.video_half_line <= 11'h7FF;
    finish_isr;
  endtask
  // Timer period of 16 cycles: it fires again after a clear.
  task automatic t_timer;
    wr32(ADDR_CONTROL, 32'h8);
    wr32(ADDR_PIT_DIV, 32'h3);
    wr32(ADDR_PIT_PRE, 32'h3);
    wait_irq;
    check(cpu_irq, 1'b1, "tick");
    wr32(ADDR_CONTROL, 32'h808);
    @(negedge pclk);
    check(cpu_irq, 1'b0, "tick clear");
    wait_irq;
    check(cpu_irq, 1'b1, "next tick");
    wr32(ADDR_PIT_PRE, 32'h0);
    wr32(ADDR_CONTROL, 32'h808);
    finish_isr;
  endtask
  // Companion input: a level already high at enable is not an edge.
  task automatic t_comp;
    wr32(ADDR_CONTROL, 32'h0);
    src.companion_irq <= 1'b1;
    wr32(ADDR_CONTROL, 32'h10);
    repeat (3) @(negedge pclk);
    check(cpu_irq, 1'b0, "level held");
    @(posedge pclk);
    src.companion_irq <= 1'b0;
    @(posedge pclk);
    src.companion_irq <= 1'b1;
    wait_irq;
    check(cpu_irq, 1'b1, "rising edge");
    rd32(ADDR_CONTROL);
    check(rd, 32'h10, "comp pending");
    src.companion_irq <= 1'b0;
    wr32(ADDR_CONTROL, 32'h1010);
    @(negedge pclk);
    check(cpu_irq, 1'b0, "comp clear");
    finish_isr;
  endtask
  // Four sources pend together, then clear one at a time.
  task automatic t_clear_all;
    wr32(ADDR_CONTROL, 32'h0);
    wr32(ADDR_PIT_PRE, 32'h1);
    pulse(1'b1, 1'b1);
    src.video_half_line <= 11'h005;
    repeat (12) @(posedge pclk);
    wr32(ADDR_PIT_PRE, 32'h0);
    src.video_half_line <= 11'h7FF;
    rd32(ADDR_CONTROL);
    check(rd, 32'hF, "all pending");
    for (int i = 0; i < 4; i++) begin
      wr32(ADDR_CONTROL, 32'h1 << (CLR_LSB + i));
      rd32(ADDR_CONTROL);
      check(rd, (32'hF << (i + 1)) & 32'hF, "clear one");
    end
  endtask
  ////////////////////////////////////////////////////////////
  // Main sequence after a three-cycle reset.
  initial begin
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check({cpu_irq, cpu_hold, bus_prio}, 4'h0, "reset outputs");
    rd32(ADDR_STATUS);
    check(rd, 32'h0, "reset status");
    t_gfx;
    t_obj;
    t_video;
    t_timer;
    t_comp;
    t_clear_all;
    rd32(32'h0);
    check(er, 1'b1, "unmapped error");
    rd32(ADDR_RESUME);
    check({er, rd[30:0]}, 32'h0, "write-only read");
    report_and_stop;
  end
  // Watchdog well beyond the few hundred cycles the tests need.
  initial begin
    #100000;
    failures++;
    $display("unexpected %0t watchdog", $time);
    report_and_stop;
  end
endmodule
